// file: include/psf_pkg.sv
// psf_pkg: register map, field positions and reset values of the port status/event flag block.
// assumes a 32-bit APB slave with byte addresses and one aligned word per register.
`default_nettype none

package psf_pkg;

	localparam int unsigned ADDR_W   = 8;
	localparam int unsigned DATA_W   = 32;
	localparam int unsigned NUM_EV   = 4;
	localparam int unsigned BDATA_W  = 16;
	localparam int unsigned CNT_W    = 16;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_ISTAT  = 8'h08;
	localparam logic [7:0] OFF_ICLR   = 8'h0C;
	localparam logic [7:0] OFF_IEN    = 8'h10;
	localparam logic [7:0] OFF_BCOUNT = 8'h14;

	// event bit positions, shared by mask, status, clear and enable
	localparam int unsigned EV_A_BYTE = 0;
	localparam int unsigned EV_A_REC  = 1;
	localparam int unsigned EV_B_BYTE = 2;
	localparam int unsigned EV_B_REC  = 3;

	// extra status fields
	localparam int unsigned ST_EMPTY_A = 4;
	localparam int unsigned ST_EMPTY_B = 5;
	localparam int unsigned ST_PAUSED  = 6;
	localparam int unsigned ST_REQ     = 7;
	localparam int unsigned ST_HOLD    = 8;

	localparam logic [3:0]  MASK_RST  = 4'h0;
	localparam logic [3:0]  IEN_RST   = 4'hF;
	localparam logic [3:0]  FLAG_RST  = 4'h0;
	localparam logic [15:0] CNT_RST   = 16'h0000;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	typedef enum logic [0:0] {
		PSF_PB_IDLE,
		PSF_PB_REQ
	} psf_pb_state_e;

endpackage

`default_nettype wire

// file: verilog/psf_hold.sv
// psf_hold: one-word holding stage between the port B pins and the compression core.
// assumes writes arrive only while in_ready is high; data output comes from a register.
`timescale 1ns/1ps
`default_nettype none

module psf_hold #(
	parameter int unsigned W = 16
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);

	if (W < 1) begin : g_chk
		$error("psf_hold: W must be at least 1");
	end

	logic         valid_reg;
	logic         valid_next;
	logic [W-1:0] data_reg;
	logic [W-1:0] data_next;

	always_comb begin
		valid_next = valid_reg;
		data_next  = data_reg;
		if (valid_reg && out_ready) begin
			valid_next = 1'b0;
		end
		if (in_valid && !valid_reg) begin
			valid_next = 1'b1;
			data_next  = in_data;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valid_reg <= 1'b0;
			data_reg  <= '0;
		end else if (ce) begin
			valid_reg <= valid_next;
			data_reg  <= data_next;
		end
	end

	assign in_ready  = !valid_reg;
	assign out_valid = valid_reg;
	assign out_data  = data_reg;

endmodule // psf_hold

`default_nettype wire

// file: verilog/psf_port_flags.sv
// psf_port_flags: per-port event flags, empty flags, pause/interrupt and port B write stop logic.
// assumes APB master on pclk, core indications and DMA strobes synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module psf_port_flags #(
	parameter int unsigned BDATA_W = psf_pkg::BDATA_W,
	parameter int unsigned CNT_W   = psf_pkg::CNT_W
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       ce,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [psf_pkg::ADDR_W-1:0] paddr,
	input  wire logic [psf_pkg::DATA_W-1:0] pwdata,
	output logic      [psf_pkg::DATA_W-1:0] prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       porta_transfer_done,
	input  wire logic                       porta_record_boundary,
	input  wire logic                       porta_core_empty,
	input  wire logic                       portb_record_boundary,
	input  wire logic                       portb_core_empty,
	output logic                            portb_transfer_request,
	input  wire logic                       portb_transfer_acknowledge,
	input  wire logic                       portb_write_strobe,
	input  wire logic [BDATA_W-1:0]         portb_data,
	output logic      [BDATA_W-1:0]         core_wdata,
	output logic                            core_wvalid,
	input  wire logic                       core_wready,
	output logic                            porta_empty_flag,
	output logic                            portb_empty_flag,
	output logic                            core_pause,
	output logic                            irq
);

	if (BDATA_W < 1 || BDATA_W > psf_pkg::DATA_W || CNT_W < 1 || CNT_W > psf_pkg::DATA_W)
	begin : g_chk
		$error("psf_port_flags: BDATA_W and CNT_W must lie in 1..32");
	end

	function automatic logic is_mapped(input logic [psf_pkg::ADDR_W-1:0] a);
		is_mapped = (a == psf_pkg::OFF_CTRL)  || (a == psf_pkg::OFF_STATUS) ||
		            (a == psf_pkg::OFF_ISTAT) || (a == psf_pkg::OFF_ICLR)   ||
		            (a == psf_pkg::OFF_IEN)   || (a == psf_pkg::OFF_BCOUNT);
	endfunction

	logic [psf_pkg::NUM_EV-1:0] mask_reg;
	logic [psf_pkg::NUM_EV-1:0] mask_next;
	logic [psf_pkg::NUM_EV-1:0] ien_reg;
	logic [psf_pkg::NUM_EV-1:0] ien_next;
	logic [psf_pkg::NUM_EV-1:0] flag_reg;
	logic [psf_pkg::NUM_EV-1:0] flag_next;
	logic [psf_pkg::NUM_EV-1:0] ev_set;
	logic [psf_pkg::NUM_EV-1:0] ev_clr;
	logic [CNT_W-1:0]           remain_reg;
	logic [CNT_W-1:0]           remain_next;
	logic                       strobe_prev_reg;
	logic                       irq_reg;
	logic                       irq_next;
	logic                       pause_reg;
	logic                       pause_next;
	logic [psf_pkg::DATA_W-1:0] prdata_reg;
	logic [psf_pkg::DATA_W-1:0] prdata_next;
	psf_pkg::psf_pb_state_e     state_reg;
	psf_pkg::psf_pb_state_e     state_next;
	logic                       wr_en;
	logic                       rd_setup;
	logic                       accept;
	logic                       pb_xfer_end;
	logic [1:0]                 xfer_end;
	logic [1:0]                 rec_end;
	logic                       hold_ready;
	logic                       hold_valid;
	logic [psf_pkg::DATA_W-1:0] status_word;

	// apb: zero wait states, frozen while ce is low
	assign pready   = ce;
	assign pslverr  = psel && penable && !is_mapped(paddr);
	assign wr_en    = ce && psel && penable && pwrite && is_mapped(paddr);
	assign rd_setup = psel && !penable && !pwrite;
	assign prdata   = prdata_reg;

	// port B handshake: strobe taken on its rising edge only while request is high
	assign accept = (state_reg == psf_pkg::PSF_PB_REQ) && portb_write_strobe &&
	                !strobe_prev_reg && portb_transfer_acknowledge;
	assign pb_xfer_end = accept && (remain_reg == CNT_W'(1));
	assign xfer_end    = {pb_xfer_end, porta_transfer_done};
	assign rec_end     = {portb_record_boundary, porta_record_boundary};

	assign ev_clr = (wr_en && paddr == psf_pkg::OFF_ICLR) ?
	                pwdata[psf_pkg::NUM_EV-1:0] : '0;

	// event source: transfer end when masked, record boundary when unmasked
	for (genvar i = 0; i < psf_pkg::NUM_EV; i++) begin : g_ev
		assign ev_set[i] = mask_reg[i] ? xfer_end[i/2]
		                               : rec_end[i/2];
	end

	always_comb begin
		mask_next   = mask_reg;
		ien_next    = ien_reg;
		remain_next = remain_reg;
		if (wr_en && paddr == psf_pkg::OFF_CTRL) begin
			mask_next = pwdata[psf_pkg::NUM_EV-1:0];
		end
		if (wr_en && paddr == psf_pkg::OFF_IEN) begin
			ien_next = pwdata[psf_pkg::NUM_EV-1:0];
		end
		if (accept) begin
			remain_next = remain_reg - CNT_W'(1);
		end
		if (wr_en && paddr == psf_pkg::OFF_BCOUNT) begin
			remain_next = pwdata[CNT_W-1:0];
		end
		// set wins over a clear in the same cycle
		flag_next  = (flag_reg & ~ev_clr) | ev_set;
		pause_next = |(flag_next & ~mask_reg);
		irq_next   = |(flag_next & ~mask_reg & ien_reg);
	end

	// request drops on each taken word, on pause, and when the count is spent
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			psf_pkg::PSF_PB_IDLE: begin
				if (remain_reg != '0 && !pause_reg && hold_ready) begin
					state_next = psf_pkg::PSF_PB_REQ;
				end
			end
			psf_pkg::PSF_PB_REQ: begin
				if (accept || pause_reg || remain_reg == '0) begin
					state_next = psf_pkg::PSF_PB_IDLE;
				end
			end
			default: begin
				state_next = psf_pkg::PSF_PB_IDLE;
			end
		endcase
	end

	always_comb begin
		status_word = '0;
		status_word[psf_pkg::NUM_EV-1:0]   = flag_reg;
		status_word[psf_pkg::ST_EMPTY_A]   = porta_empty_flag;
		status_word[psf_pkg::ST_EMPTY_B]   = portb_empty_flag;
		status_word[psf_pkg::ST_PAUSED]    = pause_reg;
		status_word[psf_pkg::ST_REQ]       = portb_transfer_request;
		status_word[psf_pkg::ST_HOLD]      = hold_valid;
		prdata_next = prdata_reg;
		if (rd_setup) begin
			case (paddr)
				psf_pkg::OFF_CTRL:   prdata_next = {{(psf_pkg::DATA_W-psf_pkg::NUM_EV){1'b0}}, mask_reg};
				psf_pkg::OFF_STATUS: prdata_next = status_word;
				psf_pkg::OFF_ISTAT:  prdata_next = {{(psf_pkg::DATA_W-psf_pkg::NUM_EV){1'b0}}, flag_reg};
				psf_pkg::OFF_IEN:    prdata_next = {{(psf_pkg::DATA_W-psf_pkg::NUM_EV){1'b0}}, ien_reg};
				psf_pkg::OFF_BCOUNT: prdata_next = psf_pkg::DATA_W'(remain_reg);
				default:             prdata_next = psf_pkg::RDATA_RST;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_reg        <= psf_pkg::MASK_RST;
			ien_reg         <= psf_pkg::IEN_RST;
			flag_reg        <= psf_pkg::FLAG_RST;
			remain_reg      <= '0;
			strobe_prev_reg <= 1'b0;
			irq_reg         <= 1'b0;
			pause_reg       <= 1'b0;
			prdata_reg      <= psf_pkg::RDATA_RST;
			state_reg       <= psf_pkg::PSF_PB_IDLE;
		end else if (ce) begin
			mask_reg        <= mask_next;
			ien_reg         <= ien_next;
			flag_reg        <= flag_next;
			remain_reg      <= remain_next;
			strobe_prev_reg <= portb_write_strobe;
			irq_reg         <= irq_next;
			pause_reg       <= pause_next;
			prdata_reg      <= prdata_next;
			state_reg       <= state_next;
		end
	end

	psf_hold #(
		.W(BDATA_W)
	) u_hold (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.in_valid (accept),
		.in_data  (portb_data),
		.in_ready (hold_ready),
		.out_valid(hold_valid),
		.out_data (core_wdata),
		.out_ready(core_wready)
	);

	assign core_wvalid            = hold_valid;
	assign portb_transfer_request = (state_reg == psf_pkg::PSF_PB_REQ);
	assign porta_empty_flag       = porta_core_empty;
	assign portb_empty_flag       = portb_core_empty && !hold_valid;
	assign core_pause             = pause_reg;
	assign irq                    = irq_reg;

endmodule // psf_port_flags

`default_nettype wire

// file: test/psf_port_flags_assertions.sv
// psf_port_flags_assertions: concurrent checks on the pins of the port flag block.
// assumes it is bound to psf_port_flags and that everything runs on pclk.
`timescale 1ns/1ps
`default_nettype none

module psf_port_flags_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic porta_core_empty,
	input wire logic portb_core_empty,
	input wire logic porta_empty_flag,
	input wire logic portb_empty_flag,
	input wire logic portb_transfer_request,
	input wire logic portb_transfer_acknowledge,
	input wire logic portb_write_strobe,
	input wire logic core_wvalid,
	input wire logic core_pause,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr;
	assign wr = psel && penable && pwrite;
	sequence s_take;
		ce && portb_transfer_request && portb_transfer_acknowledge && portb_write_strobe
			&& !$past(portb_write_strobe);
	endsequence
	sequence s_quiet;
		!wr && !$past(wr) && !$past(wr, 2);
	endsequence
	property p_empty_a; porta_empty_flag == porta_core_empty; endproperty
	property p_empty_b; core_wvalid || !portb_core_empty |-> !portb_empty_flag; endproperty
	property p_take; s_take |=> !portb_transfer_request && core_wvalid; endproperty
	property p_no_take; $rose(core_wvalid) |-> $past(portb_transfer_request); endproperty
	property p_irq_hold; irq ##0 s_quiet |=> irq; endproperty
	property p_pause_hold; core_pause ##0 s_quiet |=> core_pause; endproperty
	a_empty_a: assert property (p_empty_a) else $error("port a empty flag wrong");
	a_empty_b: assert property (p_empty_b) else $error("port b empty with data held");
	a_take: assert property (p_take) else $error("taken strobe gave no word");
	a_no_take: assert property (p_no_take) else $error("word without request");
	a_irq_hold: assert property (p_irq_hold) else $error("irq fell without software");
	a_pause_hold: assert property (p_pause_hold) else $error("pause ended early");
endmodule // psf_port_flags_assertions

bind psf_port_flags psf_port_flags_assertions psf_port_flags_assertions_i (.pclk, .presetn,
	.ce, .psel, .penable, .pwrite, .porta_core_empty, .portb_core_empty, .porta_empty_flag,
	.portb_empty_flag, .portb_transfer_request, .portb_transfer_acknowledge,
	.portb_write_strobe, .core_wvalid, .core_pause, .irq);

`default_nettype wire

// file: test/psf_dma_model.sv
// psf_dma_model: behavioural DMA master on the port B write handshake.
// assumes pclk-synchronous strobes; stray makes it strobe with no request standing.
`timescale 1ns/1ps
`default_nettype none

module psf_dma_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [3:0]  gap,
	input  wire logic        stray,
	input  wire logic        portb_transfer_request,
	output logic             portb_transfer_acknowledge,
	output logic             portb_write_strobe,
	output logic      [15:0] portb_data
);
	logic [3:0]  waited;
	logic [15:0] words;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			portb_transfer_acknowledge <= 1'h0;
			portb_write_strobe <= 1'h0;
			portb_data <= 16'h0000;
			waited <= 4'h0;
			words <= 16'h0000;
		end else if (stray) begin
			portb_transfer_acknowledge <= 1'h1;
			portb_write_strobe <= !portb_write_strobe;
			portb_data <= ~portb_data;
		end else if (portb_write_strobe) begin
			portb_transfer_acknowledge <= 1'h0;
			portb_write_strobe <= 1'h0;
			portb_data <= ~portb_data;
			words <= words + 16'h0001;
		end else if (portb_transfer_request && waited >= gap) begin
			portb_transfer_acknowledge <= 1'h1;
			portb_write_strobe <= 1'h1;
			portb_data <= 16'hC000 + words;
			waited <= 4'h0;
		end else begin
			// released bus shows a changing pattern, the old word and its inverse in turn
			portb_transfer_acknowledge <= 1'h0;
			portb_data <= ~portb_data;
			waited <= portb_transfer_request ? waited + 4'h1 : 4'h0;
		end
	end
endmodule // psf_dma_model

`default_nettype wire

// file: test/psf_port_flags_tb_top.sv
// psf_port_flags_tb_top: self-checking bench for the port flag block.
// assumes the block, its checker and the DMA model are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module psf_port_flags_tb_top;
	typedef struct packed {
		logic [3:0] mask;
		logic [1:0] ev;
		logic [3:0] flags;
		logic       pause;
	} psf_row_s;
	psf_row_s    rows [7] = '{'{4'hF, 2'h0, 4'h3, 1'h0}, '{4'hF, 2'h1, 4'h0, 1'h0},
		'{4'hF, 2'h2, 4'h0, 1'h0}, '{4'h0, 2'h0, 4'h0, 1'h0}, '{4'h0, 2'h1, 4'h3, 1'h1},
		'{4'h0, 2'h2, 4'hC, 1'h1}, '{4'h5, 2'h1, 4'h2, 1'h1}};
	logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        stray = 1'h0, wready = 1'h0, ea_in = 1'h1, eb_in = 1'h1, ce = 1'h1;
	logic [2:0]  evs = 3'h0;
	logic [3:0]  gap = 4'h3;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [15:0] bdata, wdata;
	logic        pready, pslverr, req, ack, strobe, wvalid, ea, eb, pause, irq, e;
	int          mismatches = 0, checks = 0;

	always #2.5 pclk = ~pclk;

	psf_port_flags psf_port_flags_i (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .porta_transfer_done(evs[0]),
		.porta_record_boundary(evs[1]), .porta_core_empty(ea_in), .portb_record_boundary(evs[2]),
		.portb_core_empty(eb_in), .portb_transfer_request(req), .portb_transfer_acknowledge(ack),
		.portb_write_strobe(strobe), .portb_data(bdata), .core_wdata(wdata), .core_wvalid(wvalid),
		.core_wready(wready), .porta_empty_flag(ea), .portb_empty_flag(eb), .core_pause(pause),
		.irq);
	psf_dma_model psf_dma_model_i (.pclk, .presetn, .gap, .stray, .portb_transfer_request(req),
		.portb_transfer_acknowledge(ack), .portb_write_strobe(strobe), .portb_data(bdata));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
		@(posedge pclk) penable <= 1'h1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		complete_run();
	end

	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, psf_pkg::OFF_CTRL, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, psf_pkg::OFF_IEN, 32'h0);
		chk(r, 32'hF);
		apb(1'h0, 8'h18, 32'h0);
		chk({31'h0, e}, 32'h1);
		chk({30'h0, ea, eb}, 32'h3);
		foreach (rows[i]) begin
			apb(1'h1, psf_pkg::OFF_CTRL, {28'h0, rows[i].mask});
			@(posedge pclk) evs <= 3'h1 << rows[i].ev;
			@(posedge pclk) evs <= 3'h0;
			repeat (4) @(posedge pclk);
			apb(1'h0, psf_pkg::OFF_ISTAT, 32'h0);
			chk(r, {28'h0, rows[i].flags});
			chk({30'h0, pause, irq}, {30'h0, {2{rows[i].pause}}});
			apb(1'h1, psf_pkg::OFF_ICLR, 32'hF);
			repeat (3) @(posedge pclk);
			chk({30'h0, pause, irq}, 32'h0);
		end
		apb(1'h1, psf_pkg::OFF_CTRL, 32'h4);
		apb(1'h1, psf_pkg::OFF_BCOUNT, 32'h2);
		for (int k = 0; k < 2; k++) begin
			// wait for the edge that fills the hold stage
			do begin
				@(posedge pclk);
			end while (wvalid !== 1'h1);
			chk({16'h0, wdata}, 32'hC000 + k);
			chk({31'h0, eb}, 32'h0);
			@(posedge pclk) wready <= 1'h1;
			@(posedge pclk) {wready, gap} <= 5'h00;
		end
		stray <= 1'h1;
		repeat (20) @(posedge pclk);
		chk({30'h0, req, wvalid}, 32'h0);
		stray <= 1'h0;
		apb(1'h0, psf_pkg::OFF_BCOUNT, 32'h0);
		chk(r, 32'h0);
		apb(1'h0, psf_pkg::OFF_ISTAT, 32'h0);
		chk(r, 32'h4);
		apb(1'h0, psf_pkg::OFF_STATUS, 32'h0);
		chk(r, 32'h34);
		@(posedge pclk) ea_in <= 1'h0;
		@(posedge pclk);
		chk({30'h0, ea, eb}, 32'h1);
		// record end while ce is low must be lost
		@(posedge pclk) {ce, evs} <= 4'h2;
		@(posedge pclk) {ce, evs} <= 4'h8;
		apb(1'h0, psf_pkg::OFF_ISTAT, 32'h0);
		chk(r, 32'h4);
		apb(1'h1, psf_pkg::OFF_IEN, 32'h0);
		apb(1'h0, psf_pkg::OFF_IEN, 32'h0);
		chk(r, 32'h0);
		@(posedge pclk) evs <= 3'h2;
		@(posedge pclk) evs <= 3'h0;
		repeat (3) @(posedge pclk);
		chk({30'h0, pause, irq}, 32'h2);
		complete_run();
	end
endmodule // psf_port_flags_tb_top

`default_nettype wire
